/* File: load_driver_pkg.sv */
package load_driver_pkg;

	// ==========================================
	// Register addresses and widths
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam logic [5:0] ADDR_LOAD_GLASS = 6'h02;
	localparam logic [5:0] ADDR_RECOVERY_LINK = 6'h03;

	// ==========================================
	// Reset values and writable masks
	localparam logic [15:0] LOAD_GLASS_RESET = 16'h0000;
	localparam logic [15:0] RECOVERY_LINK_RESET = 16'h0040;
	localparam logic [15:0] LOAD_GLASS_MASK = 16'h7fff;
	localparam logic [15:0] RECOVERY_LINK_MASK = 16'h7fff;

	// ==========================================
	// Load and glass control fields
	localparam int GLASS_FAST_DISCHARGE_LOW_ON_BIT = 14;
	localparam int GLASS_VOLTAGE_LOW_ON_BIT = 13;
	localparam int OUTPUT_NINE_ON_BIT = 12;
	localparam int OUTPUT_EIGHT_MODE_HI_BIT = 11;
	localparam int OUTPUT_EIGHT_MODE_LO_BIT = 10;
	localparam int OUTPUT_SEVEN_ON_BIT = 9;
	localparam int OUTPUT_SIX_ON_BIT = 8;
	localparam int GLASS_NEGATIVE_DISCHARGE_BIT = 7;
	localparam int GLASS_REF_BIT5 = 6;
	localparam int GLASS_REF_BIT0 = 1;
	localparam int GLASS_CONTROL_ENABLE_BIT = 0;

	// ==========================================
	// Recovery and link control fields
	localparam int RETRY_RATE_SELECT_BIT = 14;
	localparam int SUPPLY_FAULT_LATCH_BIT = 13;
	localparam int BRIDGE_FIVE_AUTO_RETRY_BIT = 12;
	localparam int BRIDGE_ONE_AUTO_RETRY_BIT = 8;
	localparam int BUS_FAST_RATE_BIT = 7;
	localparam int TX_DOMINANT_TIMEOUT_EN_BIT = 6;
	localparam int GLASS_VOLTAGE_LIMIT_BIT = 5;
	localparam int BRIDGE_FIVE_GATE_PWM_A_BIT = 4;
	localparam int BRIDGE_ONE_GATE_PWM_A_BIT = 0;

	// ==========================================
	// Output-eight mode codes
	localparam logic [1:0] EIGHT_HIGH_CURRENT = 2'h2;
	localparam logic [1:0] EIGHT_LOW_CURRENT = 2'h1;

	// ==========================================
	// Timing
	localparam int BRIDGES = 5;
	localparam int SINGLES = 5;
	localparam int CLK_HZ = 20_000_000;
	localparam int RETRY_SLOW_HZ = 1700;
	localparam int RETRY_FAST_HZ = 3000;
	localparam int RETRY_SLOW_CYCLES = CLK_HZ / RETRY_SLOW_HZ;
	localparam int RETRY_FAST_CYCLES = CLK_HZ / RETRY_FAST_HZ;
	localparam int RETRY_CNT_W = 16;

endpackage

/* File: pwm_gate.sv */
`timescale 1ns/10ps
module pwm_gate #(
	parameter int N = 5
) (
	// Enables and gating selects
	input wire logic [N-1:0] enable_i,
	input wire logic [N-1:0] gate_i,
	input wire logic [N-1:0] pwm_i,
	input wire logic [N-1:0] block_i,
	// Drive result
	output logic [N-1:0] on_o
);

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1)
		begin : gate_bit
			assign on_o[g] = enable_i[g] & (~gate_i[g] | pwm_i[g]) & ~block_i[g];
		end
	endgenerate

endmodule

/* File: retry_tick_gen.sv */
`timescale 1ns/10ps
module retry_tick_gen #(
	parameter int SLOW_CYCLES = load_driver_pkg::RETRY_SLOW_CYCLES,
	parameter int FAST_CYCLES = load_driver_pkg::RETRY_FAST_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Rate select
	input wire logic fast_i,
	// Retry strobe
	output logic tick_o
);

	localparam logic [load_driver_pkg::RETRY_CNT_W-1:0] SLOW_LAST =
		load_driver_pkg::RETRY_CNT_W'(SLOW_CYCLES - 1);
	localparam logic [load_driver_pkg::RETRY_CNT_W-1:0] FAST_LAST =
		load_driver_pkg::RETRY_CNT_W'(FAST_CYCLES - 1);

	logic [load_driver_pkg::RETRY_CNT_W-1:0] cnt_r;
	logic [load_driver_pkg::RETRY_CNT_W-1:0] cnt_nxt;
	logic tick_r;
	wire logic [load_driver_pkg::RETRY_CNT_W-1:0] last_w = fast_i ? FAST_LAST : SLOW_LAST;
	wire logic wrap_w = (cnt_r >= last_w);

	assign cnt_nxt = wrap_w ? '0 : cnt_r + 1'b1;
	assign tick_o = tick_r;

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			tick_r <= wrap_w;
		end
	end

endmodule

/* File: load_driver_control_regs.sv */
// Summary of operation
// - Reserved bits are written zero by host and always read back zero.
// - Fast-discharge low-side bit switches that driver on at one, off at zero.
// - Glass-voltage low-side bit enables driver; with its gate bit it follows pwm a.
// - Output nine bit enables driver; with its gate bit it follows pwm a.
// - Output eight field: 10 high current, 01 low current, 00 or 11 off.
// - Enabled output eight with its gate bit follows pwm c.
// - Output seven bit enables driver; with its gate bit it follows pwm a.
// - While glass control is enabled, output seven is on unless a supply fault blocks it.
// - Output six bit enables driver; with its gate bit it follows pwm b.
// - Negative-discharge bit turns the negative discharge path on or off.
// - Six-bit glass reference, scaled by the limit bit; zero gives zero.
// - Glass control enable bit activates glass voltage regulation.
// - Retry rate select: 1.7 kHz at zero, 3 kHz at one.
// - Supply fault latch bit holds outputs off until status clear.
// - Bridge auto-retry restarts at retry rate; otherwise wait for status clear.
// - Bus fast rate bit selects 20 or 100 kbit/s.
// - Transmit timeout bit enables the dominant transmit-data timeout.
// - Glass voltage limit: 1.2V at zero, 1.5V at one.
// - Enabled bridge with gate bit set drives on while pwm a high.
// - Recovery and link register at 03h resets to zero except bit 6.
`timescale 1ns/10ps
module load_driver_control_regs #(
	parameter int RETRY_SLOW_CYCLES = load_driver_pkg::RETRY_SLOW_CYCLES,
	parameter int RETRY_FAST_CYCLES = load_driver_pkg::RETRY_FAST_CYCLES,
	parameter int BRIDGES = load_driver_pkg::BRIDGES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Register access from the serial frame decoder
	input wire logic [load_driver_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [load_driver_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [load_driver_pkg::DATA_W-1:0] reg_rdata_o,
	// Gating selects held in the fourth control register
	input wire logic glass_voltage_gate_pwm_a_i,
	input wire logic output_nine_gate_pwm_a_i,
	input wire logic output_eight_gate_pwm_c_i,
	input wire logic output_seven_gate_pwm_a_i,
	input wire logic output_six_gate_pwm_b_i,
	// Bridge on requests from the first control register
	input wire logic [BRIDGES-1:0] bridge_request_i,
	// PWM inputs
	input wire logic pwm_input_a_i,
	input wire logic pwm_input_b_i,
	input wire logic pwm_input_c_i,
	// Fault detectors and status clear
	input wire logic [BRIDGES-1:0] bridge_overcurrent_i,
	input wire logic supply_fault_i,
	input wire logic status_clear_i,
	// Driver controls
	output logic glass_fast_discharge_low_on_o,
	output logic glass_voltage_low_on_o,
	output logic output_nine_on_o,
	output logic output_eight_on_o,
	output logic output_eight_high_current_o,
	output logic output_seven_on_o,
	output logic output_six_on_o,
	output logic [BRIDGES-1:0] bridge_drive_o,
	// Glass regulation
	output logic glass_control_enable_o,
	output logic glass_negative_discharge_o,
	output logic [5:0] glass_ref_o,
	output logic glass_voltage_limit_o,
	// Recovery and link settings
	output logic retry_rate_select_o,
	output logic bus_fast_rate_o,
	output logic tx_dominant_timeout_en_o,
	output logic [BRIDGES-1:0] bridge_blocked_o
);

	// ==========================================
	// Register storage
	logic [15:0] load_glass_r;
	logic [15:0] recovery_link_r;
	logic [15:0] rdata_r;

	wire logic sel_load_glass = (reg_addr_i == load_driver_pkg::ADDR_LOAD_GLASS);
	wire logic sel_recovery_link = (reg_addr_i == load_driver_pkg::ADDR_RECOVERY_LINK);
	wire logic wr_load_glass = reg_wr_i & sel_load_glass;
	wire logic wr_recovery_link = reg_wr_i & sel_recovery_link;
	wire logic [15:0] load_glass_nxt = reg_wdata_i & load_driver_pkg::LOAD_GLASS_MASK;
	wire logic [15:0] recovery_link_nxt = reg_wdata_i & load_driver_pkg::RECOVERY_LINK_MASK;
	// Unmapped addresses read back zero
	wire logic [15:0] rdata_nxt = sel_load_glass ? load_glass_r :
		sel_recovery_link ? recovery_link_r : 16'h0000;

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			load_glass_r <= load_driver_pkg::LOAD_GLASS_RESET;
			recovery_link_r <= load_driver_pkg::RECOVERY_LINK_RESET;
		end
		else
		begin
			if (wr_load_glass)
				load_glass_r <= load_glass_nxt;
			if (wr_recovery_link)
				recovery_link_r <= recovery_link_nxt;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			rdata_r <= 16'h0000;
		else if (reg_rd_i)
			rdata_r <= rdata_nxt;
	end

	assign reg_rdata_o = rdata_r;

	// ==========================================
	// Field decode
	wire logic fast_discharge_bit = load_glass_r[load_driver_pkg::GLASS_FAST_DISCHARGE_LOW_ON_BIT];
	wire logic glass_low_bit = load_glass_r[load_driver_pkg::GLASS_VOLTAGE_LOW_ON_BIT];
	wire logic nine_bit = load_glass_r[load_driver_pkg::OUTPUT_NINE_ON_BIT];
	wire logic [1:0] eight_mode = {load_glass_r[load_driver_pkg::OUTPUT_EIGHT_MODE_HI_BIT],
		load_glass_r[load_driver_pkg::OUTPUT_EIGHT_MODE_LO_BIT]};
	wire logic seven_bit = load_glass_r[load_driver_pkg::OUTPUT_SEVEN_ON_BIT];
	wire logic six_bit = load_glass_r[load_driver_pkg::OUTPUT_SIX_ON_BIT];
	wire logic neg_discharge_bit = load_glass_r[load_driver_pkg::GLASS_NEGATIVE_DISCHARGE_BIT];
	wire logic [5:0] glass_ref =
		load_glass_r[load_driver_pkg::GLASS_REF_BIT5:load_driver_pkg::GLASS_REF_BIT0];
	wire logic glass_enable_bit = load_glass_r[load_driver_pkg::GLASS_CONTROL_ENABLE_BIT];

	wire logic rate_bit = recovery_link_r[load_driver_pkg::RETRY_RATE_SELECT_BIT];
	wire logic supply_latch_bit = recovery_link_r[load_driver_pkg::SUPPLY_FAULT_LATCH_BIT];
	wire logic [BRIDGES-1:0] auto_retry = recovery_link_r[
		load_driver_pkg::BRIDGE_FIVE_AUTO_RETRY_BIT:load_driver_pkg::BRIDGE_ONE_AUTO_RETRY_BIT];
	wire logic fast_rate_bit = recovery_link_r[load_driver_pkg::BUS_FAST_RATE_BIT];
	wire logic tx_timeout_bit = recovery_link_r[load_driver_pkg::TX_DOMINANT_TIMEOUT_EN_BIT];
	wire logic limit_bit = recovery_link_r[load_driver_pkg::GLASS_VOLTAGE_LIMIT_BIT];
	wire logic [BRIDGES-1:0] bridge_gate = recovery_link_r[
		load_driver_pkg::BRIDGE_FIVE_GATE_PWM_A_BIT:load_driver_pkg::BRIDGE_ONE_GATE_PWM_A_BIT];

	wire logic eight_high = (eight_mode == load_driver_pkg::EIGHT_HIGH_CURRENT);
	wire logic eight_low = (eight_mode == load_driver_pkg::EIGHT_LOW_CURRENT);
	wire logic eight_enable = eight_high | eight_low;

	// ==========================================
	// Overcurrent retry timing
	logic retry_tick;

	retry_tick_gen #(
		.SLOW_CYCLES(RETRY_SLOW_CYCLES),
		.FAST_CYCLES(RETRY_FAST_CYCLES)
	) u_retry_tick (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.fast_i(rate_bit),
		.tick_o(retry_tick)
	);

	// ==========================================
	// Supply fault hold-off
	logic supply_hold_r;
	wire logic supply_hold_nxt = supply_latch_bit &
		(supply_fault_i | (supply_hold_r & ~status_clear_i));
	wire logic supply_block = supply_fault_i | supply_hold_r;

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			supply_hold_r <= 1'b0;
		else
			supply_hold_r <= supply_hold_nxt;
	end

	// ==========================================
	// Bridge overcurrent latches, set beats clear
	logic [BRIDGES-1:0] oc_latch_r;
	logic [BRIDGES-1:0] oc_latch_nxt;
	logic [BRIDGES-1:0] oc_release;

	genvar b;
	generate
		for (b = 0; b < BRIDGES; b = b + 1)
		begin : bridge_latch
			assign oc_release[b] = auto_retry[b] ? retry_tick : status_clear_i;
			assign oc_latch_nxt[b] = bridge_overcurrent_i[b] |
				(oc_latch_r[b] & ~oc_release[b]);
		end
	endgenerate

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			oc_latch_r <= '0;
		else
			oc_latch_r <= oc_latch_nxt;
	end

	wire logic [BRIDGES-1:0] bridge_block = oc_latch_r | {BRIDGES{supply_block}};

	// ==========================================
	// PWM gating
	logic [BRIDGES-1:0] bridge_on;
	logic [4:0] single_on;

	pwm_gate #(
		.N(BRIDGES)
	) u_bridge_gate (
		.enable_i(bridge_request_i),
		.gate_i(bridge_gate),
		.pwm_i({BRIDGES{pwm_input_a_i}}),
		.block_i(bridge_block),
		.on_o(bridge_on)
	);

	// Order: glass low, nine, eight, seven, six
	pwm_gate #(
		.N(5)
	) u_single_gate (
		.enable_i({glass_low_bit, nine_bit, eight_enable, seven_bit, six_bit}),
		.gate_i({glass_voltage_gate_pwm_a_i, output_nine_gate_pwm_a_i,
			output_eight_gate_pwm_c_i, output_seven_gate_pwm_a_i, output_six_gate_pwm_b_i}),
		.pwm_i({pwm_input_a_i, pwm_input_a_i, pwm_input_c_i, pwm_input_a_i, pwm_input_b_i}),
		.block_i({5{supply_block}}),
		.on_o(single_on)
	);

	// Glass forcing still yields to a supply fault block
	wire logic seven_on = glass_enable_bit ? ~supply_block : single_on[1];

	// ==========================================
	// Registered outputs
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			glass_fast_discharge_low_on_o <= 1'b0;
			glass_voltage_low_on_o <= 1'b0;
			output_nine_on_o <= 1'b0;
			output_eight_on_o <= 1'b0;
			output_eight_high_current_o <= 1'b0;
			output_seven_on_o <= 1'b0;
			output_six_on_o <= 1'b0;
		end
		else
		begin
			glass_fast_discharge_low_on_o <= fast_discharge_bit;
			glass_voltage_low_on_o <= single_on[4];
			output_nine_on_o <= single_on[3];
			output_eight_on_o <= single_on[2];
			output_eight_high_current_o <= eight_high;
			output_seven_on_o <= seven_on;
			output_six_on_o <= single_on[0];
		end
	end

	// Bridge drives and their block flags
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			bridge_drive_o <= '0;
			bridge_blocked_o <= '0;
		end
		else
		begin
			bridge_drive_o <= bridge_on;
			bridge_blocked_o <= bridge_block;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			glass_control_enable_o <= 1'b0;
			glass_negative_discharge_o <= 1'b0;
			glass_ref_o <= 6'h00;
			glass_voltage_limit_o <= 1'b0;
		end
		else
		begin
			glass_control_enable_o <= glass_enable_bit;
			glass_negative_discharge_o <= neg_discharge_bit;
			glass_ref_o <= glass_ref;
			glass_voltage_limit_o <= limit_bit;
		end
	end

	// Recovery and link settings
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			retry_rate_select_o <= 1'b0;
			bus_fast_rate_o <= 1'b0;
			tx_dominant_timeout_en_o <= 1'b1;
		end
		else
		begin
			retry_rate_select_o <= rate_bit;
			bus_fast_rate_o <= fast_rate_bit;
			tx_dominant_timeout_en_o <= tx_timeout_bit;
		end
	end

endmodule

/* File: load_driver_control_regs_props.sv */
`timescale 1ns/10ps
module load_driver_control_regs_props #(
	parameter int BRIDGES = 5
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Watched ports
	input wire logic [5:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic output_six_gate_pwm_b_i,
	input wire logic [BRIDGES-1:0] bridge_request_i,
	input wire logic pwm_input_b_i,
	input wire logic glass_fast_discharge_low_on_o,
	input wire logic output_eight_high_current_o,
	input wire logic output_seven_on_o,
	input wire logic output_six_on_o,
	input wire logic [BRIDGES-1:0] bridge_drive_o,
	input wire logic glass_control_enable_o,
	input wire logic [5:0] glass_ref_o,
	input wire logic glass_voltage_limit_o,
	input wire logic retry_rate_select_o,
	input wire logic bus_fast_rate_o,
	input wire logic tx_dominant_timeout_en_o,
	input wire logic [BRIDGES-1:0] bridge_blocked_o
);
	// ====
	// Decodes
	logic wr_lg;
	logic wr_rl;
	logic any_blk;
	assign wr_lg = reg_wr_i && reg_addr_i == 6'h02;
	assign wr_rl = reg_wr_i && reg_addr_i == 6'h03;
	assign any_blk = |bridge_blocked_o;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// ====
	// Properties
	a_top_bit_zero: assert property (reg_rdata_o[15] == 1'b0)
		else $error("read bit 15 not zero");
	a_ref_from_write: assert property (wr_lg |-> ##2 glass_ref_o == $past(reg_wdata_i[6:1], 2))
		else $error("glass reference wrong");
	a_fast_dis_write: assert property (wr_lg |-> ##2
		glass_fast_discharge_low_on_o == $past(reg_wdata_i[14], 2))
		else $error("fast discharge wrong");
	a_eight_mode_code: assert property (wr_lg |-> ##2
		output_eight_high_current_o == ($past(reg_wdata_i[11:10], 2) == 2'h2))
		else $error("output eight mode wrong");
	a_limit_from_write: assert property (wr_rl |-> ##2
		glass_voltage_limit_o == $past(reg_wdata_i[5], 2))
		else $error("voltage limit wrong");
	a_retry_rate_write: assert property (wr_rl |-> ##2
		retry_rate_select_o == $past(reg_wdata_i[14], 2))
		else $error("retry rate wrong");
	a_link_bits_write: assert property (wr_rl |-> ##2
		{bus_fast_rate_o, tx_dominant_timeout_en_o} == $past(reg_wdata_i[7:6], 2))
		else $error("link settings wrong");
	a_seven_held_on: assert property (glass_control_enable_o && !any_blk && !$past(any_blk)
		&& !$past(any_blk, 2) |-> output_seven_on_o)
		else $error("output seven not forced on");
	a_bridge_needs_req: assert property (|(bridge_drive_o & ~$past(bridge_request_i)) == 1'b0)
		else $error("bridge driven without request");
	a_six_gated_pwm: assert property (output_six_on_o && $past(output_six_gate_pwm_b_i)
		|-> $past(pwm_input_b_i))
		else $error("output six on while pwm low");
endmodule
bind load_driver_control_regs load_driver_control_regs_props #(.BRIDGES(BRIDGES)) u_props (
	.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
	.output_six_gate_pwm_b_i, .bridge_request_i, .pwm_input_b_i,
	.glass_fast_discharge_low_on_o, .output_eight_high_current_o, .output_seven_on_o,
	.output_six_on_o, .bridge_drive_o, .glass_control_enable_o, .glass_ref_o,
	.glass_voltage_limit_o, .retry_rate_select_o, .bus_fast_rate_o,
	.tx_dominant_timeout_en_o, .bridge_blocked_o);

/* File: host_model.sv */
`timescale 1ns/10ps
module host_model (
	// Clock
	input wire logic ref_clk_i,
	// Register port
	output logic [5:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [15:0] reg_wdata_o,
	output logic reg_rd_o,
	input wire logic [15:0] reg_rdata_i
);
	initial
	begin
		reg_addr_o = 6'h3f;
		reg_wr_o = 1'b0;
		reg_wdata_o = 16'h0000;
		reg_rd_o = 1'b0;
	end
	// ====
	// Accesses; released lines show inverted values
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		#1;
		d = reg_rdata_i;
	endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [5:0] addr;
	logic wr;
	logic rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [4:0] gate_sel = 5'h1f;
	logic [4:0] req = 5'h00;
	logic [4:0] oc = 5'h00;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic pc = 1'b0;
	logic sfault = 1'b0;
	logic sclr = 1'b0;
	logic fdis, glow, nine, eight, eight_hi, seven, six, gen, gneg, glim, rate, fast, tmo;
	logic [5:0] gref;
	logic [4:0] drive;
	logic [4:0] blk;
	int n_fail = 0;
	int check_count = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	host_model u_host_model (.ref_clk_i(ref_clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
		.reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata));
	load_driver_control_regs #(.RETRY_SLOW_CYCLES(20), .RETRY_FAST_CYCLES(10), .BRIDGES(5))
		u_load_driver_control_regs (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .glass_voltage_gate_pwm_a_i(gate_sel[0]),
		.output_nine_gate_pwm_a_i(gate_sel[1]), .output_eight_gate_pwm_c_i(gate_sel[2]),
		.output_seven_gate_pwm_a_i(gate_sel[3]), .output_six_gate_pwm_b_i(gate_sel[4]),
		.bridge_request_i(req), .pwm_input_a_i(pa), .pwm_input_b_i(pb), .pwm_input_c_i(pc),
		.bridge_overcurrent_i(oc), .supply_fault_i(sfault), .status_clear_i(sclr),
		.glass_fast_discharge_low_on_o(fdis), .glass_voltage_low_on_o(glow),
		.output_nine_on_o(nine), .output_eight_on_o(eight),
		.output_eight_high_current_o(eight_hi), .output_seven_on_o(seven),
		.output_six_on_o(six), .bridge_drive_o(drive), .glass_control_enable_o(gen),
		.glass_negative_discharge_o(gneg), .glass_ref_o(gref), .glass_voltage_limit_o(glim),
		.retry_rate_select_o(rate), .bus_fast_rate_o(fast), .tx_dominant_timeout_en_o(tmo),
		.bridge_blocked_o(blk));
	// ====
	// Shared helpers
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd_chk(input string nm, input logic [5:0] a, input logic [15:0] e);
		logic [15:0] d;
		u_host_model.rd(a, d);
		chk(nm, e, d);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic pulse_fault(input logic [4:0] o, input logic s);
		@(posedge ref_clk_i);
		oc <= o;
		sfault <= s;
		@(posedge ref_clk_i);
		oc <= 5'h00;
		sfault <= 1'b0;
		settle(2);
	endtask
	task automatic clear_status;
		@(posedge ref_clk_i);
		sclr <= 1'b1;
		@(posedge ref_clk_i);
		sclr <= 1'b0;
		settle(3);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ====
	// Scenarios
	task automatic t_reset;
		rd_chk("reg02 reset", 6'h02, 16'h0000);
		rd_chk("reg03 reset", 6'h03, 16'h0040);
		chk("timeout reset", 16'h0001, 16'(tmo));
	endtask
	task automatic t_reserved;
		u_host_model.wr(6'h02, 16'hffff);
		rd_chk("reg02 top bit", 6'h02, 16'h7fff);
		u_host_model.wr(6'h03, 16'hffff);
		rd_chk("reg03 top bit", 6'h03, 16'h7fff);
		u_host_model.wr(6'h05, 16'h1234);
		rd_chk("unmapped", 6'h05, 16'h0000);
	endtask
	task automatic t_link;
		u_host_model.wr(6'h03, 16'h4000);
		settle(2);
		chk("retry rate", 16'h0001, 16'(rate));
		chk("timeout off", 16'h0000, 16'(tmo));
		u_host_model.wr(6'h03, 16'h00a0);
		settle(2);
		chk("link and limit", 16'h0005, {13'h0, fast, rate, glim});
	endtask
	task automatic t_glass;
		u_host_model.wr(6'h02, 16'h40d5);
		settle(2);
		chk("glass ref", 16'h002a, 16'(gref));
		chk("glass flags", 16'h000f, {12'h0, gen, gneg, fdis, seven});
		u_host_model.wr(6'h02, 16'h0000);
		settle(2);
		chk("glass off", 16'h0000, {9'h0, gref, seven});
		chk("glass flags off", 16'h0000, {13'h0, gen, gneg, fdis});
	endtask
	task automatic t_eight;
		@(posedge ref_clk_i);
		pc <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			u_host_model.wr(6'h02, 16'(i) << 10);
			settle(2);
			chk("eight decode", {14'h0, i == 1 || i == 2, i == 2}, {14'h0, eight, eight_hi});
		end
	endtask
	task automatic t_pwm;
		u_host_model.wr(6'h02, 16'h3b00);
		u_host_model.wr(6'h03, 16'h001f);
		@(posedge ref_clk_i);
		req <= 5'h1f;
		for (int p = 0; p < 8; p++)
		begin
			@(posedge ref_clk_i);
			{pc, pb, pa} <= p[2:0];
			settle(1);
			chk("pwm a outs", {13'h0, {3{p[0]}}}, {13'h0, nine, seven, glow});
			chk("pwm b c outs", {14'h0, p[1], p[2]}, {14'h0, six, eight});
			chk("bridges", {11'h0, {5{p[0]}}}, {11'h0, drive});
		end
		@(posedge ref_clk_i);
		gate_sel <= 5'h00;
		{pc, pb, pa} <= 3'h0;
		settle(1);
		chk("ungated outs", 16'h001f, {11'h0, nine, seven, glow, six, eight});
		@(posedge ref_clk_i);
		gate_sel <= 5'h1f;
		pa <= 1'b1;
	endtask
	task automatic t_fault;
		int n;
		pulse_fault(5'h01, 1'b0);
		settle(30);
		chk("latched bridge", 16'h0010, {11'h0, blk[0], drive[0], 3'h0});
		clear_status();
		chk("cleared bridge", 16'h0001, {14'h0, blk[0], drive[0]});
		u_host_model.wr(6'h03, 16'h011f);
		@(posedge ref_clk_i);
		oc <= 5'h01;
		settle(3);
		chk("retry start", 16'h0001, 16'(blk[0]));
		@(posedge ref_clk_i);
		oc <= 5'h00;
		n = 0;
		while (blk[0] !== 1'b0 && n < 30)
		begin
			settle(1);
			n++;
		end
		if (n >= 30)
		begin
			n_fail++;
			$display("[ERR] retry release expected 0 seen 1");
		end
		u_host_model.wr(6'h03, 16'h201f);
		pulse_fault(5'h00, 1'b1);
		settle(5);
		chk("supply latched", 16'h003e, {10'h0, blk, nine});
		clear_status();
		chk("supply cleared", 16'h0001, {10'h0, blk, nine});
		u_host_model.wr(6'h03, 16'h001f);
		pulse_fault(5'h00, 1'b1);
		chk("supply auto", 16'h0000, 16'(blk));
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_reserved();
		t_link();
		t_glass();
		t_eight();
		t_pwm();
		t_fault();
		conclude();
	end
endmodule
